// file: verilog/tdmbp_pkg.sv
// shared constants and carrier types for the tdm backplane and host pin block
package tdmbp_pkg;
    localparam int FRAME_SLOTS = 32;
    localparam int SLOT_BITS = 8;
    localparam int SLOT_CNT_W = 5;
    localparam int BIT_CNT_W = 3;
    localparam int CLK_MHZ = 125;
    localparam int STREAM_KBPS = 2048;
    // bit period in clock cycles, rounded down (shorter interval)
    localparam int BIT_CYCLES = (CLK_MHZ * 1000) / STREAM_KBPS;
    localparam int BIT_CYC_W = 7;
    localparam int RESET_MIN_NS = 1000;
    // least reset width rounds up to whole cycles
    localparam int RESET_MIN_CYCLES = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_CNT_W = 8;
    localparam logic [7:0] CAS_TS_FIRST = 8'h01;
    localparam logic [7:0] CAS_TS_LAST = 8'h1f;
    localparam logic [7:0] CAS_TS_SKIP = 8'h10;
    localparam logic [3:0] NIBBLE_IDLE = 4'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // host bus pin group
    typedef struct packed {
        logic chip_select_n;
        logic data_or_read_strobe_n;
        logic bus_style_select;
    } tdmbp_host_t;

    // one transmit slot captured from the backplane
    typedef struct packed {
        logic [4:0] slot;
        logic [7:0] data;
        logic [3:0] sig;
        logic sig_valid;
    } tdmbp_tx_slot_t;
endpackage

// file: verilog/tdmbp_backplane.sv
// backplane tdm streams and host control pins of the framer system side
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - signalling status output carries 24 or 30 receive nibbles, one per slot, 2.048 Mbit/s
// - select 1: upper nibble valid, lower tristated; select 0: swapped
// - signalling control input used when source select 0, ignored when 1
// - select 1 uses upper input nibble, 0 uses lower; other ignored
// - serial data output carries 24 or 30 received channels at 2.048 Mbit/s
// - host strobe input is active low; data strobe or read strobe by style
// - host bus responds only with chip select low; else all bus pins high-z
// - open-drain interrupt pulls low when pending outside device reset, independent of chip select
// - bus style high selects separate strobes, low selects data strobe style
module tdmbp_backplane #(
    parameter int BIT_CYCLES = tdmbp_pkg::BIT_CYCLES,
    parameter int RESET_MIN_CYCLES = tdmbp_pkg::RESET_MIN_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reset_n_i,
    input wire tdmbp_pkg::tdmbp_host_t host_i,
    input wire logic nibble_position_select_i,
    input wire logic signalling_source_select_i,
    input wire logic t1_mode_i,
    input wire logic [7:0] rx_data_i,
    input wire logic [3:0] rx_sig_i,
    input wire logic irq_pending_i,
    input wire logic serial_data_in_i,
    input wire logic signalling_control_in_i,
    output logic serial_data_out_o,
    output logic signalling_status_out_o,
    output logic signalling_status_oe_o,
    output logic frame_pulse_o,
    output logic bit_strobe_o,
    output logic [4:0] rx_slot_o,
    output tdmbp_pkg::tdmbp_tx_slot_t tx_slot_o,
    output logic tx_slot_valid_o,
    output logic bus_data_oe_o,
    output logic bus_read_o,
    output logic bus_write_o,
    output logic irq_n_o,
    output logic irq_oe_o,
    output logic device_reset_o
);
    logic [tdmbp_pkg::BIT_CYC_W-1:0] div_reg;
    logic [tdmbp_pkg::SLOT_CNT_W-1:0] slot_reg;
    logic [tdmbp_pkg::BIT_CNT_W-1:0] bit_reg;
    logic [7:0] tx_shift_reg;
    logic [7:0] out_shift_reg;
    logic [3:0] sig_hold_reg;
    logic [tdmbp_pkg::RST_CNT_W-1:0] rst_cnt_reg;
    logic rst_ok_reg;
    logic dev_rst_reg;

    // channel qualification: t1 carries 24 channels, e1 the 30 cas slots
    function automatic logic slot_carries(input logic [4:0] s, input logic t1);
        logic [7:0] w;
        w = {3'h0, s};
        if (t1)
            slot_carries = (w >= tdmbp_pkg::CAS_TS_FIRST) && (w <= 8'h18);
        else
            slot_carries = (w >= tdmbp_pkg::CAS_TS_FIRST) && (w <= tdmbp_pkg::CAS_TS_LAST)
                && (w != tdmbp_pkg::CAS_TS_SKIP);
    endfunction

    // bit timing; 125 MHz is not a whole multiple of the bit rate, slight drift
    wire bit_tick = (div_reg == tdmbp_pkg::BIT_CYC_W'(BIT_CYCLES - 1));
    wire last_bit = (bit_reg == tdmbp_pkg::BIT_CNT_W'(tdmbp_pkg::SLOT_BITS - 1));
    wire last_slot = (slot_reg == tdmbp_pkg::SLOT_CNT_W'(tdmbp_pkg::FRAME_SLOTS - 1));
    wire [4:0] next_slot = last_slot ? 5'h00 : slot_reg + 5'h01;
    wire next_sig_ok = slot_carries(next_slot, t1_mode_i);
    wire next_dat_ok = slot_carries(next_slot, t1_mode_i);
    // reload word for the next slot; idle slots send zero
    wire [7:0] load_data = next_dat_ok ? rx_data_i : tdmbp_pkg::DATA_RESET;
    // upper half of the slot is bits 7..4 when msb goes first
    wire upper_half = ~bit_reg[2];
    wire sig_half_valid = nibble_position_select_i ? upper_half : ~upper_half;
    wire cur_sig_ok = slot_carries(slot_reg, t1_mode_i);
    // captured transmit word; select 1 keeps upper nibble, 0 the lower
    wire [7:0] tx_word = {tx_shift_reg[6:0], serial_data_in_i};
    wire [3:0] cap_sig = nibble_position_select_i ? sig_hold_reg : {sig_hold_reg[2:0],
        signalling_control_in_i};
    wire sig_use = ~signalling_source_select_i & cur_sig_ok;
    wire cs_active = ~host_i.chip_select_n & rst_ok_reg;
    wire strobe = ~host_i.data_or_read_strobe_n;

    // reset pin qualifier: shorter lows are treated as glitches
    always_ff @(posedge clk_i) begin
        if (rst_i || reset_n_i) begin
            rst_cnt_reg <= '0;
        end else if (rst_cnt_reg != tdmbp_pkg::RST_CNT_W'(RESET_MIN_CYCLES)) begin
            rst_cnt_reg <= rst_cnt_reg + 1'b1;
        end
    end

    // device reset held from a qualified low until the pin rises
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dev_rst_reg <= 1'b1;
            rst_ok_reg <= 1'b0;
        end else begin
            if (rst_cnt_reg == tdmbp_pkg::RST_CNT_W'(RESET_MIN_CYCLES))
                dev_rst_reg <= 1'b1;
            else if (reset_n_i)
                dev_rst_reg <= 1'b0;
            rst_ok_reg <= reset_n_i & ~dev_rst_reg;
        end
    end

    // frame counters: 32 slots of 8 bits
    always_ff @(posedge clk_i) begin
        if (rst_i || dev_rst_reg) begin
            div_reg <= '0;
            bit_reg <= '0;
            slot_reg <= '0;
        end else if (bit_tick) begin
            div_reg <= '0;
            bit_reg <= bit_reg + 1'b1;
            if (last_bit)
                slot_reg <= next_slot;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // receive shifters, msb first
    always_ff @(posedge clk_i) begin
        if (rst_i || dev_rst_reg) begin
            out_shift_reg <= tdmbp_pkg::DATA_RESET;
            serial_data_out_o <= 1'b0;
            signalling_status_out_o <= 1'b0;
            signalling_status_oe_o <= 1'b0;
        end else if (bit_tick) begin
            if (last_bit)
                out_shift_reg <= load_data;
            else
                out_shift_reg <= {out_shift_reg[6:0], 1'b0};
            serial_data_out_o <= last_bit ? load_data[7] : out_shift_reg[6];
            // outputs for the coming bit; nibble carries rx code when valid
            signalling_status_oe_o <= last_bit ? (next_sig_ok & nibble_position_select_i)
                : (cur_sig_ok & (nibble_position_select_i ? (bit_reg < 3'h3)
                : (bit_reg >= 3'h3)));
            signalling_status_out_o <= last_bit ? rx_sig_i[3]
                : rx_sig_i[2'(3'h2 - bit_reg[1:0])];
        end
    end

    // transmit capture on the last clock of each bit period; signalling only within its selected nibble
    always_ff @(posedge clk_i) begin
        if (rst_i || dev_rst_reg) begin
            tx_shift_reg <= '0;
            sig_hold_reg <= tdmbp_pkg::NIBBLE_IDLE;
            tx_slot_o <= '0;
            tx_slot_valid_o <= 1'b0;
        end else begin
            tx_slot_valid_o <= 1'b0;
            if (bit_tick) begin
                tx_shift_reg <= tx_word;
                if (sig_half_valid && !(last_bit && !nibble_position_select_i))
                    sig_hold_reg <= {sig_hold_reg[2:0], signalling_control_in_i};
                if (last_bit) begin
                    tx_slot_o.slot <= slot_reg;
                    tx_slot_o.data <= tx_word;
                    tx_slot_o.sig <= sig_use ? cap_sig : tdmbp_pkg::NIBBLE_IDLE;
                    tx_slot_o.sig_valid <= sig_use;
                    tx_slot_valid_o <= 1'b1;
                end
            end
        end
    end

    // timing marks, host bus decode and interrupt pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_pulse_o <= 1'b0;
            bit_strobe_o <= 1'b0;
            rx_slot_o <= '0;
            bus_data_oe_o <= 1'b0;
            bus_read_o <= 1'b0;
            bus_write_o <= 1'b0;
            irq_n_o <= 1'b1;
            irq_oe_o <= 1'b0;
            device_reset_o <= 1'b1;
        end else begin
            frame_pulse_o <= bit_tick & last_bit & last_slot;
            bit_strobe_o <= bit_tick;
            rx_slot_o <= slot_reg;
            // separate strobes: strobe is read; data strobe style: strobe is write
            bus_data_oe_o <= cs_active & strobe;
            bus_read_o <= cs_active & strobe & host_i.bus_style_select;
            bus_write_o <= cs_active & strobe & ~host_i.bus_style_select;
            // open drain: drive low only, never high, regardless of chip select
            irq_n_o <= 1'b0;
            irq_oe_o <= irq_pending_i & ~dev_rst_reg;
            device_reset_o <= dev_rst_reg;
        end
    end
endmodule

`default_nettype wire

// file: verification/tdmbp_props.sv
// port-level assertions for the tdm backplane and host pin block
`timescale 1ns/1ps
`default_nettype none
module tdmbp_props #(
    parameter int BIT_CYCLES = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reset_n_i,
    input wire tdmbp_pkg::tdmbp_host_t host_i,
    input wire logic signalling_source_select_i,
    input wire logic irq_pending_i,
    input wire logic bit_strobe_o,
    input wire logic [4:0] rx_slot_o,
    input wire tdmbp_pkg::tdmbp_tx_slot_t tx_slot_o,
    input wire logic tx_slot_valid_o,
    input wire logic bus_data_oe_o,
    input wire logic bus_read_o,
    input wire logic bus_write_o,
    input wire logic irq_n_o,
    input wire logic irq_oe_o,
    input wire logic device_reset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a host strobe inside an active chip select
    wire logic rd_req = !host_i.chip_select_n && !host_i.data_or_read_strobe_n;
    // reset counts below assume the shortened minimum of 3 cycles
    property p_idle; host_i.chip_select_n |=> !bus_data_oe_o && !bus_read_o && !bus_write_o; endproperty
    a_idle: assert property (p_idle) else $error("bus driven while deselected");
    // a low reset pin blocks the bus one cycle later even before the device reset rises
    property p_rd; rd_req && host_i.bus_style_select && !device_reset_o && $past(reset_n_i) |=> bus_read_o && bus_data_oe_o; endproperty
    a_rd: assert property (p_rd) else $error("read strobe not answered");
    property p_irq; !$past(rst_i) && !device_reset_o |-> irq_oe_o == $past(irq_pending_i) && !irq_n_o; endproperty
    a_irq: assert property (p_irq) else $error("interrupt pin not following request");
    // a device reset restarts the bit timing, so a missing strobe is excused then
    property p_bit; bit_strobe_o |-> ##BIT_CYCLES (bit_strobe_o || device_reset_o); endproperty
    a_bit: assert property (p_bit) else $error("bit period wrong");
    property p_slot; rx_slot_o != $past(rx_slot_o) && !device_reset_o |-> rx_slot_o == $past(rx_slot_o) + 5'h01; endproperty
    a_slot: assert property (p_slot) else $error("slot order broken");
    property p_sig_off; tx_slot_valid_o && signalling_source_select_i && $past(signalling_source_select_i, 40) |-> !tx_slot_o.sig_valid && tx_slot_o.sig == 4'h0; endproperty
    a_sig_off: assert property (p_sig_off) else $error("ignored signalling used");
    // three counted lows, one cycle to raise the hold, one to the output flop
    property p_dev_on; !reset_n_i [*6] |-> device_reset_o; endproperty
    a_dev_on: assert property (p_dev_on) else $error("long reset pulse not taken");
    property p_dev_off; reset_n_i [*4] |-> !device_reset_o; endproperty
    a_dev_off: assert property (p_dev_off) else $error("device held in reset");
    c_rd: cover property (rd_req && host_i.bus_style_select);
    c_sig: cover property (tx_slot_valid_o && tx_slot_o.sig_valid);
    c_dev: cover property (device_reset_o && !reset_n_i);
endmodule
`default_nettype wire

// file: verification/tdmbp_switch.sv
// backplane switch model feeding the transmit data and signalling streams
`timescale 1ns/1ps
`default_nettype none
module tdmbp_switch (
    input wire logic clk_i,
    input wire logic frame_rst_i,
    input wire logic strobe_i,
    input wire logic [7:0] data_i,
    input wire logic [7:0] sig_i,
    output logic sd_o,
    output logic sc_o
);
    logic [2:0] bit_reg;
    // moves just after each strobe so the bit stands a full period
    // realigns to bit 0 while the device is held in reset, as its counters do
    always_ff @(negedge clk_i) begin
        if (frame_rst_i) begin
            bit_reg <= 3'h0;
        end else if (strobe_i) begin
            bit_reg <= bit_reg + 3'h1;
        end
    end
    // eight bits a slot, msb first; the unused nibble is never idle-looking
    assign sd_o = data_i[3'h7 - bit_reg];
    assign sc_o = sig_i[3'h7 - bit_reg];
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the tdm backplane and host pin block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic reset_n_i = 1'b1;
    tdmbp_pkg::tdmbp_host_t host_i = 3'b110;
    logic nibble_position_select_i = 1'b0;
    logic signalling_source_select_i = 1'b0;
    logic t1_mode_i = 1'b0;
    logic irq_pending_i = 1'b0;
    logic [7:0] rx_data_i = 8'h00;
    logic [3:0] rx_sig_i = 4'h9;
    logic [7:0] pat = 8'h00;
    logic [7:0] spat = 8'h00;
    logic serial_data_in_i, signalling_control_in_i, serial_data_out_o, signalling_status_out_o;
    logic signalling_status_oe_o, frame_pulse_o, bit_strobe_o, tx_slot_valid_o, bus_data_oe_o;
    logic bus_read_o, bus_write_o, irq_n_o, irq_oe_o, device_reset_o;
    logic [4:0] rx_slot_o;
    tdmbp_pkg::tdmbp_tx_slot_t tx_slot_o;
    int fail_count = 0;
    int checks = 0;
    always #4 clk_i = ~clk_i;
    // short bit period and reset minimum keep the run brief
    tdmbp_backplane #(.BIT_CYCLES(4), .RESET_MIN_CYCLES(3)) DUT (.*);
    tdmbp_switch u_sw (.clk_i(clk_i), .frame_rst_i(device_reset_o), .strobe_i(bit_strobe_o),
        .data_i(pat), .sig_i(spat),
        .sd_o(serial_data_in_i), .sc_o(signalling_control_in_i));
    task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // read answered, then released on deselect even with strobe held
    task automatic t_host();
        host_i = 3'b001;
        step(2);
        chk("bus_read", 8'h01, bus_read_o);
        host_i = 3'b100;
        step(2);
        chk("bus_oe", 8'h00, {bus_data_oe_o, bus_read_o, bus_write_o});
    endtask
    // interrupt works with chip select high
    task automatic t_irq();
        irq_pending_i = 1'b1;
        step(2);
        chk("irq", 8'h02, {irq_oe_o, irq_n_o});
        irq_pending_i = 1'b0;
        step(2);
        chk("irq_off", 8'h00, irq_oe_o);
    endtask
    // short pulse ignored, long pulse resets and blocks the bus
    task automatic t_reset();
        reset_n_i = 1'b0;
        step(2);
        reset_n_i = 1'b1;
        step(1);
        chk("short_rst", 8'h00, device_reset_o);
        reset_n_i = 1'b0;
        host_i = 3'b001;
        step(6);
        chk("long_rst", 8'h02, {device_reset_o, bus_read_o});
        reset_n_i = 1'b1;
        host_i = 3'b110;
        step(4);
        chk("rst_end", 8'h00, device_reset_o);
    endtask
    // one frame slot both ways under a mode, nibble and source setting
    task automatic t_stream(input logic t1, input logic ns, input logic sr);
        logic [7:0] d, s, e;
        int n, k, f;
        t1_mode_i = t1;
        nibble_position_select_i = ns;
        signalling_source_select_i = sr;
        pat = {t1, ns, sr, 5'h0d};
        spat = ns ? 8'ha5 : 8'h5a;
        rx_data_i = ~{t1, ns, sr, 5'h0d};
        k = 0;
        f = 0;
        for (n = 0; n < 6000 && k < 2; n++) begin
            step(1);
            if (tx_slot_valid_o === 1'b1 && tx_slot_o.slot === 5'h05) k++;
            if (k == 1 && frame_pulse_o === 1'b1) f++;
        end
        chk("tx_wait", 8'h02, k[7:0]);
        chk("frame_pulse", 8'h01, f[7:0]);
        chk("tx_data", pat, tx_slot_o.data);
        chk("tx_sig", sr ? 8'h00 : 8'h0a, {tx_slot_o.sig_valid, 3'h0, tx_slot_o.sig} ^ {!sr, 7'h0});
        for (n = 0; n < 3000 && rx_slot_o !== 5'h05; n++) step(1);
        chk("rx_wait", 8'h05, {3'h0, rx_slot_o});
        step(2);
        for (int b = 7; b >= 0; b--) begin
            d[b] = serial_data_out_o;
            s[b] = signalling_status_out_o;
            e[b] = signalling_status_oe_o;
            step(4);
        end
        chk("rx_data", rx_data_i, d);
        chk("rx_sig_oe", ns ? 8'hf0 : 8'h0f, e);
        chk("rx_sig", ns ? 8'h90 : 8'h09, s & e);
    endtask
    initial begin
        step(5);
        rst_i = 1'b0;
        step(4);
        t_host();
        t_irq();
        t_reset();
        for (int i = 0; i < 4; i++) t_stream(i[1], i[0], i[1] ^ i[0]);
        give_verdict();
    end
    // hang guard, well past four streamed frames pairs
    initial begin
        #400000;
        fail_count++;
        give_verdict();
    end
endmodule
bind tdmbp_backplane tdmbp_props #(.BIT_CYCLES(BIT_CYCLES)) u_props (.*);
`default_nettype wire
